// ---- core/fpb_defines.vh ----
`ifndef FPB_DEFINES_VH
`define FPB_DEFINES_VH
`define FPB_OP_XFER_B1 8'h53
`define FPB_OP_XFER_B2 8'h55
`define FPB_OP_CMP_B1 8'h60
`define FPB_OP_CMP_B2 8'h61
`define FPB_OP_REWR_B1 8'h58
`define FPB_OP_REWR_B2 8'h59
`define FPB_OP_STATUS 8'hD7
`define FPB_CMD_BITS 6'h20
`define FPB_OPC_LAST 6'h07
`define FPB_P528_HI 22
`define FPB_P528_LO 10
`define FPB_P512_HI 21
`define FPB_P512_LO 9
`define FPB_ST_RDY 7
`define FPB_ST_COMP 6
`define FPB_ST_DENS_HI 5
`define FPB_ST_DENS_LO 2
`define FPB_ST_PROT 1
`define FPB_ST_PSIZE 0
`define FPB_COMP_RST 1'b0
`define FPB_MOP_XFER 2'h0
`define FPB_MOP_CMP 2'h1
`define FPB_MOP_PROG 2'h2
`endif

// ---- core/fpb_flash_cmd.v ----
// Overview of operation
// - Opcode 53h loads a page into buffer one, 55h into buffer two.
// - In 528-byte mode the address holds one dummy, 13 page bits, ten dummies.
// - In 512-byte mode the address holds two dummies, 13 page bits, nine dummies.
// - Opcode and address clock in with select low; work starts on select rising.
// - Transfer shows busy in the ready flag until it completes.
// - Opcode 60h compares against buffer one, 61h against buffer two.
// - Compare starts on select rising, busy throughout, result lands in bit 6.
// - Mismatch flag is 0 on equal contents, 1 when any bit differs.
// - Opcode 58h rewrites through buffer one, 59h through buffer two.
// - Rewrite copies the page to the buffer then programs it back, busy throughout.
// - Opcode D7h starts status read; status bits follow on every clock.
// - After the second status byte the first byte is sent again, repeating.
// - Status read is accepted any time and each byte carries fresh contents.
// - Ready flag sits in both status bytes, resampled for every byte.
// - Select rising ends status read at once and releases the output.
// - Status bit 7 reads 0 while busy and 1 when ready.
// - Status bits 5 to 2 give a fixed four-bit density code.
// - Status bit 1 reads 1 when sector protection is enabled.
// - Status bit 0 reads 0 for 528-byte pages, 1 for 512-byte pages.
`timescale 1ns/1ps
`include "fpb_defines.vh"
module fpb_flash_cmd #(
   // Density code value is arbitrary.
   parameter [3:0] DENSITY_CODE = 4'h6
) (
   input wire CLOCK,
   input wire SYS_RST,
   input wire CS_N,
   input wire SCK,
   input wire SI,
   output wire SO,
   output wire SO_OE,
   input wire PROTECT_EN,
   input wire PAGE_512,
   output wire MEM_REQ,
   output wire [1:0] MEM_OP,
   output wire MEM_BUF,
   output wire [12:0] MEM_PAGE,
   input wire MEM_ACK,
   input wire MEM_DIFF
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_XFER = 2'h1;
   localparam [1:0] ST_CMP = 2'h2;
   localparam [1:0] ST_PROG = 2'h3;

   reg [2:0] cs_sync_q;
   reg [2:0] sck_sync_q;
   reg [1:0] si_sync_q;
   reg [1:0] prot_sync_q;
   reg [1:0] psize_sync_q;
   reg [5:0] bit_cnt_q;
   reg [7:0] in_sr_q;
   reg [7:0] opcode_q;
   reg [23:0] addr_q;
   reg stat_mode_q;
   reg [7:0] out_sr_q;
   reg [2:0] out_cnt_q;
   reg out_sel_q;
   reg so_q;
   reg so_oe_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg rewrite_q;
   reg rewrite_d;
   reg buf_q;
   reg buf_d;
   reg [12:0] page_q;
   reg [12:0] page_d;
   reg comp_q;
   reg comp_d;
   reg [1:0] mem_op;
   reg [7:0] stat_byte1;
   reg [7:0] stat_byte2;

   wire cs_high;
   wire cs_rise;
   wire sck_rise;
   wire sck_fall;
   wire si_s;
   wire [7:0] in_sr_d;
   wire busy;
   wire [7:0] stat_next;
   wire cmd_full;
   wire [12:0] page_sel;

   // Pins cross from the host's clock; stage one feeds only stage two.
   always @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         cs_sync_q <= 3'h7;
         sck_sync_q <= 3'h0;
      end
      else
      begin
         cs_sync_q <= {cs_sync_q[1:0], CS_N};
         sck_sync_q <= {sck_sync_q[1:0], SCK};
      end
   end

   // Data and strap pins need no edge stage, so two flops suffice.
   always @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         si_sync_q <= 2'h0;
         prot_sync_q <= 2'h0;
         psize_sync_q <= 2'h0;
      end
      else
      begin
         si_sync_q <= {si_sync_q[0], SI};
         prot_sync_q <= {prot_sync_q[0], PROTECT_EN};
         psize_sync_q <= {psize_sync_q[0], PAGE_512};
      end
   end

   assign cs_high = cs_sync_q[1];
   assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
   assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
   assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
   assign si_s = si_sync_q[1];
   assign in_sr_d = {in_sr_q[6:0], si_s};
   assign busy = (state_q != ST_IDLE);
   assign cmd_full = (bit_cnt_q == `FPB_CMD_BITS);

   // Page index position depends on the configured page size.
   assign page_sel = psize_sync_q[1] ? addr_q[`FPB_P512_HI:`FPB_P512_LO]
                                     : addr_q[`FPB_P528_HI:`FPB_P528_LO];

   always @*
   begin
      stat_byte1 = 8'h00;
      stat_byte1[`FPB_ST_RDY] = ~busy;
      stat_byte1[`FPB_ST_COMP] = comp_q;
      stat_byte1[`FPB_ST_DENS_HI:`FPB_ST_DENS_LO] = DENSITY_CODE;
      stat_byte1[`FPB_ST_PROT] = prot_sync_q[1];
      stat_byte1[`FPB_ST_PSIZE] = psize_sync_q[1];
   end

   // Byte two carries only the ready flag; its other fields are not kept here.
   always @*
   begin
      stat_byte2 = 8'h00;
      stat_byte2[`FPB_ST_RDY] = ~busy;
   end

   assign stat_next = out_sel_q ? stat_byte2 : stat_byte1;

   // Serial input side: opcode then three address bytes; bit count and status mode cleared while deselected.
   always @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         bit_cnt_q <= 6'h00;
         in_sr_q <= 8'h00;
         opcode_q <= 8'h00;
         addr_q <= 24'h000000;
         stat_mode_q <= 1'b0;
      end
      else if (cs_high)
      begin
         bit_cnt_q <= 6'h00;
         stat_mode_q <= 1'b0;
      end
      else if (sck_rise)
      begin
         in_sr_q <= in_sr_d;
         if (bit_cnt_q != `FPB_CMD_BITS)
         begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
         if (bit_cnt_q == `FPB_OPC_LAST)
         begin
            opcode_q <= in_sr_d;
            if (in_sr_d == `FPB_OP_STATUS)
            begin
               stat_mode_q <= 1'b1;
            end
         end
         else if (bit_cnt_q > `FPB_OPC_LAST && bit_cnt_q != `FPB_CMD_BITS)
         begin
            addr_q <= {addr_q[22:0], si_s};
         end
      end
   end

   // Status output side: bits change on falling clock, each byte built fresh.
   always @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         out_sr_q <= 8'h00;
         out_cnt_q <= 3'h0;
         out_sel_q <= 1'b0;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end
      else if (cs_high)
      begin
         out_cnt_q <= 3'h0;
         out_sel_q <= 1'b0;
         so_oe_q <= 1'b0;
      end
      else if (sck_fall && stat_mode_q)
      begin
         so_oe_q <= 1'b1;
         out_cnt_q <= out_cnt_q + 3'h1;
         if (out_cnt_q == 3'h0)
         begin
            // Sampling at the byte boundary keeps a byte self-consistent.
            out_sr_q <= {stat_next[6:0], 1'b0};
            so_q <= stat_next[7];
         end
         else
         begin
            out_sr_q <= {out_sr_q[6:0], 1'b0};
            so_q <= out_sr_q[7];
            if (out_cnt_q == 3'h7)
            begin
               out_sel_q <= ~out_sel_q;
            end
         end
      end
   end

   assign SO = so_q;
   assign SO_OE = so_oe_q;

   // Self-timed sequencer. A command arriving while busy is dropped.
   always @*
   begin
      state_d = state_q;
      rewrite_d = rewrite_q;
      buf_d = buf_q;
      page_d = page_q;
      comp_d = comp_q;
      case (state_q)
         ST_IDLE:
         begin
            if (cs_rise && cmd_full)
            begin
               page_d = page_sel;
               rewrite_d = 1'b0;
               case (opcode_q)
                  `FPB_OP_XFER_B1, `FPB_OP_XFER_B2:
                  begin
                     state_d = ST_XFER;
                     buf_d = opcode_q[2];
                  end
                  `FPB_OP_CMP_B1, `FPB_OP_CMP_B2:
                  begin
                     state_d = ST_CMP;
                     buf_d = opcode_q[0];
                  end
                  `FPB_OP_REWR_B1, `FPB_OP_REWR_B2:
                  begin
                     state_d = ST_XFER;
                     rewrite_d = 1'b1;
                     buf_d = opcode_q[0];
                  end
                  default:
                  begin
                     state_d = ST_IDLE;
                  end
               endcase
            end
         end
         ST_XFER:
         begin
            if (MEM_ACK)
            begin
               state_d = rewrite_q ? ST_PROG : ST_IDLE;
            end
         end
         ST_CMP:
         begin
            if (MEM_ACK)
            begin
               comp_d = MEM_DIFF;
               state_d = ST_IDLE;
            end
         end
         ST_PROG:
         begin
            if (MEM_ACK)
            begin
               state_d = ST_IDLE;
               rewrite_d = 1'b0;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge CLOCK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_q <= ST_IDLE;
         rewrite_q <= 1'b0;
         buf_q <= 1'b0;
         page_q <= 13'h0000;
         comp_q <= `FPB_COMP_RST;
      end
      else
      begin
         state_q <= state_d;
         rewrite_q <= rewrite_d;
         buf_q <= buf_d;
         page_q <= page_d;
         comp_q <= comp_d;
      end
   end

   assign MEM_REQ = busy;
   // Idle shows the transfer code, so the operation field never floats.
   always @*
   begin
      case (state_q)
         ST_CMP:
         begin
            mem_op = `FPB_MOP_CMP;
         end
         ST_PROG:
         begin
            mem_op = `FPB_MOP_PROG;
         end
         default:
         begin
            mem_op = `FPB_MOP_XFER;
         end
      endcase
   end

   assign MEM_OP = mem_op;
   assign MEM_BUF = buf_q;
   assign MEM_PAGE = page_q;
endmodule

// ---- testbench/fpb_array_model.sv ----
`timescale 1ns/1ps
module fpb_array_model (
   input wire clock,
   input wire rst,
   input wire req,
   input wire [12:0] page,
   output reg ack_q,
   output wire diff
);
   reg [7:0] cnt_q;
   // Odd pages mismatch; low page bits make the answer slow or prompt.
   assign diff = page[0];
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 8'h00;
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= req && !ack_q && cnt_q == {page[2:0], 5'h1F};
         cnt_q <= req && !ack_q ? cnt_q + 8'h01 : 8'h00;
      end
   end
endmodule

// ---- testbench/fpb_flash_cmd_properties.sv ----
`timescale 1ns/1ps
module fpb_flash_cmd_properties (
   input wire CLOCK,
   input wire SYS_RST,
   input wire CS_N,
   input wire SCK,
   input wire SO_OE,
   input wire MEM_REQ,
   input wire [1:0] MEM_OP,
   input wire MEM_ACK
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_OP))
      else $error("busy lost");
   oe_off_a: assert property (CS_N [*5] |-> !SO_OE) else $error("output on");
   start_sel_a: assert property ($rose(MEM_REQ) |-> CS_N && $past(CS_N, 3))
      else $error("early start");
   first_op_a: assert property ($rose(MEM_REQ) |-> MEM_OP != 2'h2) else $error("bad op");
   op_step_a: assert property (MEM_REQ && $past(MEM_REQ) && $changed(MEM_OP)
      |-> $past(MEM_ACK) && MEM_OP == 2'h2) else $error("bad step");
   req_fall_a: assert property ($fell(MEM_REQ) |-> $past(MEM_ACK)) else $error("no ack");
   done_end_a: assert property (MEM_REQ && MEM_ACK && MEM_OP != 2'h0 |=> !MEM_REQ)
      else $error("busy stuck");
   oe_rise_a: assert property ($rose(SO_OE) |-> !CS_N && !$past(SCK, 2))
      else $error("early output");
   cover property ($rose(MEM_REQ) && MEM_OP == 2'h1);
   cover property (MEM_REQ && MEM_OP == 2'h2);
   cover property ($fell(SO_OE));
endmodule
bind fpb_flash_cmd fpb_flash_cmd_properties i_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
   .CS_N(CS_N), .SCK(SCK), .SO_OE(SO_OE), .MEM_REQ(MEM_REQ), .MEM_OP(MEM_OP),
   .MEM_ACK(MEM_ACK));

// ---- testbench/fpb_flash_cmd_test.sv ----
`timescale 1ns/1ps
module fpb_flash_cmd_test;
   // Density value is arbitrary.
   localparam [3:0] DENS = 4'h9;
   reg clock = 1'b0, sck = 1'b0, si = 1'b0, p512 = 1'b0, comp = 1'b0;
   reg sys_rst = 1'b1, cs_n = 1'b1, prot = 1'b1;
   reg [31:0] q;
   integer n_errors = 0, compares = 0;
   wire so, so_oe, req, bsel, ack, diff;
   wire [1:0] mop;
   wire [12:0] page;
   fpb_flash_cmd #(.DENSITY_CODE(DENS)) i_dut (.CLOCK(clock), .SYS_RST(sys_rst),
      .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe), .PROTECT_EN(prot),
      .PAGE_512(p512), .MEM_REQ(req), .MEM_OP(mop), .MEM_BUF(bsel), .MEM_PAGE(page),
      .MEM_ACK(ack), .MEM_DIFF(diff));
   fpb_array_model i_mem (.clock(clock), .rst(sys_rst), .req(req), .page(page),
      .ack_q(ack), .diff(diff));
   initial forever #20 clock = ~clock;
   initial
   begin
      #2000000;
      n_errors = n_errors + 1;
      finish_test;
   end
   task check(input string name, input [31:0] seen, input [31:0] exp);
      compares = compares + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task shift(input [31:0] d, input integer n);
      integer i;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
         sck = 1'b0;
         si = d[i];
         repeat (4) @(negedge clock);
         sck = 1'b1;
         repeat (4) @(negedge clock);
         q = {q[30:0], so};
      end
   endtask
   task close;
      sck = 1'b0;
      repeat (4) @(negedge clock);
      cs_n = 1'b1;
      repeat (8) @(negedge clock);
   endtask
   task stat(input integer n);
      cs_n = 1'b0;
      shift(32'hD7, 8);
      shift(32'h0, n);
      close;
   endtask
   task run_op(input [7:0] op, input pm, input [12:0] pg);
      integer k;
      p512 = pm;
      repeat (4) @(negedge clock);
      cs_n = 1'b0;
      shift({op, pm ? {2'b11, pg, 9'h1FF} : {1'b1, pg, 10'h3FF}}, 32);
      close;
      check("req", {req, bsel, page}, {1'b1, op[0] & (op != 8'h53), pg});
      for (k = 0; k < 600 && op[3] && mop !== 2'h2; k = k + 1)
         @(negedge clock);
      check("phase", mop, {op[3], op[5]});
      stat(16);
      check("busy", {q[15], q[7]}, 2'b00);
      for (k = 0; k < 20 && q[15] !== 1'b1; k = k + 1)
         stat(16);
      if (op[5])
         comp = pg[0];
      check("status", q[15:0], {1'b1, comp, DENS, prot, pm, 8'h80});
   endtask
   task finish_test;
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      stat(20);
      check("stat", q[19:0], {2'b10, DENS, 10'h280, 2'b10, DENS[3:2]});
      check("hiz", so_oe, 1'b0);
      run_op(8'h53, 1'b0, 13'h1AB7);
      run_op(8'h55, 1'b1, 13'h0546);
      prot = 1'b0;
      run_op(8'h60, 1'b0, 13'h1AB7);
      run_op(8'h61, 1'b1, 13'h0546);
      run_op(8'h58, 1'b0, 13'h0546);
      run_op(8'h59, 1'b1, 13'h1AB7);
      finish_test;
   end
endmodule
